// *** common/avdma_pkg.sv ***
package avdma_pkg;
  // ***************************************************
  // device register offsets
  // ***************************************************
  localparam logic [7:0] DEV_BM_CMD = 8'h00;
  localparam logic [7:0] DEV_PRD_ADDR = 8'h04;
  localparam logic [7:0] DEV_LB_CMD = 8'h10;
  localparam logic [7:0] DEV_LB_PRD = 8'h14;
  localparam logic [7:0] DEV_TF_STAT = 8'h20;
  localparam logic [7:0] DEV_CFG_STAT = 8'h24;
  localparam logic [7:0] DEV_CHUNK = 8'h28;

  // ***************************************************
  // field positions and values
  // ***************************************************
  localparam int BM_EN = 0;
  localparam int BM_DIR = 3;
  localparam int BM_ACT = 16;
  localparam int BM_ERR = 17;
  localparam int BM_INT = 18;
  localparam int TF_STAT_LSB = 24;
  localparam int TF_DRQ = 27;
  localparam int TF_ERR = 24;
  localparam int CFG_DEVINT = 11;
  localparam int CFG_VDONE = 10;
  localparam int DESC_SIZE_LSB = 32;
  localparam int DESC_UPPER_LSB = 48;
  localparam int DESC_LAST = 63;
  localparam logic [31:0] LEGACY_SPAN = 32'h0001_0000;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] DESC_HALF = 32'h0000_0004;

  // ***************************************************
  // controller (host end) register offsets and fields
  // ***************************************************
  localparam logic [7:0] HR_CTRL = 8'h00;
  localparam logic [7:0] HR_WDATA = 8'h04;
  localparam logic [7:0] HR_RDATA = 8'h08;
  localparam logic [7:0] HR_STATUS = 8'h0C;
  localparam int HC_GO = 31;
  localparam int HC_WR = 8;

  // gray codes along fetch -> move path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH_LO = 3'h1,
    ST_FETCH_HI = 3'h3,
    ST_FIRST = 3'h2,
    ST_SECOND = 3'h6
  } avdma_state_t;
endpackage

// *** common/avdma_if.sv ***
`timescale 1ns/10ps
// register access path plus the channel interrupt line
interface avdma_if;
  logic req; // access request, held until ack
  logic we; // 1 = write
  logic [7:0] addr; // register offset
  logic [31:0] wdata; // write data
  logic [31:0] rdata; // read data, valid with ack
  logic ack; // one-cycle completion pulse
  logic intr; // channel interrupt level
  modport dev (input req, we, addr, wdata, output rdata, ack, intr);
  modport host (output req, we, addr, wdata, input rdata, ack, intr);
endinterface

// *** hw/avdma_desc_dec.sv ***
`timescale 1ns/10ps
module avdma_desc_dec (
  input wire logic [63:0] i_desc, // fetched descriptor
  input wire logic i_large, // large block interpretation
  output logic [31:0] o_addr, // region start
  output logic [31:0] o_len, // usable bytes of region
  output logic o_last // final descriptor flag
);
  logic [31:0] size16;
  logic [31:0] room;

  // legacy: size 0 means 64k, and a region never crosses 64k
  always_comb begin
    size16 = {16'h0, i_desc[avdma_pkg::DESC_SIZE_LSB +: 16]};
    if (size16 == 32'h0) begin
      size16 = avdma_pkg::LEGACY_SPAN;
    end
    room = avdma_pkg::LEGACY_SPAN - {16'h0, i_desc[15:0]};
    if (i_large) begin
      o_len = {1'b0, i_desc[avdma_pkg::DESC_UPPER_LSB +: 15],
               i_desc[avdma_pkg::DESC_SIZE_LSB +: 16]};
    end else begin
      o_len = (size16 < room) ? size16 : room;
    end
  end

  assign o_addr = i_desc[31:0];
  assign o_last = i_desc[avdma_pkg::DESC_LAST];
endmodule

// *** hw/avdma_dev.sv ***
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps
module avdma_dev (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_resetn, // async reset, low
  avdma_if.dev bus, // register access from host
  input wire logic [7:0] i_ata_status, // ATA status byte
  input wire logic i_ata_intrq, // ATA interrupt line
  output logic o_ata_stat_rd, // pulse: status read
  output logic o_pio_req, // PIO cycle request
  output logic o_pio_we, // 1 = write to ATA
  output logic [31:0] o_pio_wdata, // PIO write word
  input wire logic i_pio_ack, // PIO cycle done
  input wire logic [31:0] i_pio_rdata, // PIO read word
  output logic o_mem_req, // memory cycle request
  output logic o_mem_we, // 1 = write to memory
  output logic [31:0] o_mem_addr, // memory byte address
  output logic [31:0] o_mem_wdata, // memory write word
  input wire logic i_mem_ack, // memory cycle done
  input wire logic i_mem_err, // with ack: failed
  input wire logic [31:0] i_mem_rdata // memory read word
);
  // ***************************************************
  // declarations
  // ***************************************************
  avdma_pkg::avdma_state_t state_q;
  logic ack_q, en_q, dir_q, large_q, act_q, err_q, int_q;
  logic devint_q, vdone_q, last_q;
  logic [31:0] rdata_q, prd_q, chunk_q, ptr_q, dlo_q, raddr_q, rem_q, data_q;
  logic [31:0] rd_d, dec_addr, dec_len;
  logic dec_last, acc, wr, rd, cmd_wr, start, stop, w1c_int, w1c_err;
  logic fetch, first_ack, step_ack, mem_ack, fail, chunk_end, region_end;
  logic finish, short_tbl, tf_rd;

  // ***************************************************
  // register access decode
  // ***************************************************
  assign acc = bus.req & ~ack_q;
  assign wr = acc & bus.we;
  assign rd = acc & ~bus.we;
  assign cmd_wr = wr & (bus.addr == avdma_pkg::DEV_BM_CMD | bus.addr == avdma_pkg::DEV_LB_CMD);
  assign start = cmd_wr & bus.wdata[avdma_pkg::BM_EN] & ~en_q;
  assign stop = cmd_wr & ~bus.wdata[avdma_pkg::BM_EN];
  assign w1c_int = cmd_wr & bus.wdata[avdma_pkg::BM_INT];
  assign w1c_err = cmd_wr & bus.wdata[avdma_pkg::BM_ERR];
  // a locked-out read never touches the device interrupt
  assign tf_rd = rd & (bus.addr == avdma_pkg::DEV_TF_STAT) & ~en_q;
  assign o_ata_stat_rd = tf_rd;

  // ***************************************************
  // transfer engine events
  // ***************************************************
  assign fetch = (state_q == avdma_pkg::ST_FETCH_LO) | (state_q == avdma_pkg::ST_FETCH_HI);
  assign mem_ack = o_mem_req & i_mem_ack;
  assign fail = mem_ack & i_mem_err;
  assign first_ack = (state_q == avdma_pkg::ST_FIRST) & (dir_q ? i_pio_ack : i_mem_ack);
  assign step_ack = (state_q == avdma_pkg::ST_SECOND) & (dir_q ? i_mem_ack : i_pio_ack) & ~fail;
  assign chunk_end = step_ack & (chunk_q == avdma_pkg::WORD_BYTES);
  assign region_end = step_ack & (rem_q == avdma_pkg::WORD_BYTES);
  assign finish = chunk_end;
  assign short_tbl = ~chunk_end & region_end & last_q;

  // bit3 set: ATA read then memory write; clear: the reverse
  assign o_pio_req = ((state_q == avdma_pkg::ST_FIRST) & dir_q) |
                     ((state_q == avdma_pkg::ST_SECOND) & ~dir_q);
  assign o_pio_we = ~dir_q;
  assign o_pio_wdata = data_q;
  assign o_mem_req = fetch | ((state_q == avdma_pkg::ST_FIRST) & ~dir_q) |
                     ((state_q == avdma_pkg::ST_SECOND) & dir_q);
  assign o_mem_we = (state_q == avdma_pkg::ST_SECOND) & dir_q;
  assign o_mem_addr = fetch ? ptr_q : raddr_q;
  assign o_mem_wdata = data_q;

  avdma_desc_dec u_dec (
    .i_desc({i_mem_rdata, dlo_q}),
    .i_large(large_q),
    .o_addr(dec_addr),
    .o_len(dec_len),
    .o_last(dec_last)
  );

  // ***************************************************
  // state machine
  // ***************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= avdma_pkg::ST_IDLE;
    end else if (stop | fail) begin
      state_q <= avdma_pkg::ST_IDLE;
    end else if (start) begin
      state_q <= avdma_pkg::ST_FETCH_LO;
    end else begin
      case (state_q)
        avdma_pkg::ST_IDLE: state_q <= avdma_pkg::ST_IDLE;
        avdma_pkg::ST_FETCH_LO: if (mem_ack) state_q <= avdma_pkg::ST_FETCH_HI;
        avdma_pkg::ST_FETCH_HI: if (mem_ack) state_q <= avdma_pkg::ST_FIRST;
        avdma_pkg::ST_FIRST: if (first_ack) state_q <= avdma_pkg::ST_SECOND;
        avdma_pkg::ST_SECOND: begin
          if (finish | short_tbl) begin
            state_q <= avdma_pkg::ST_IDLE;
          end else if (region_end) begin
            state_q <= avdma_pkg::ST_FETCH_LO;
          end else if (step_ack) begin
            state_q <= avdma_pkg::ST_FIRST;
          end
        end
        default: state_q <= avdma_pkg::ST_IDLE;
      endcase
    end
  end

  // descriptor pointer, region and data word
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr_q <= 32'h0;
      dlo_q <= 32'h0;
      raddr_q <= 32'h0;
      rem_q <= 32'h0;
      last_q <= 1'b0;
      data_q <= 32'h0;
    end else begin
      if (start) begin
        ptr_q <= prd_q;
      end else if (fetch & mem_ack) begin
        ptr_q <= ptr_q + avdma_pkg::DESC_HALF;
      end
      if ((state_q == avdma_pkg::ST_FETCH_LO) & mem_ack) begin
        dlo_q <= i_mem_rdata;
      end
      if ((state_q == avdma_pkg::ST_FETCH_HI) & mem_ack) begin
        raddr_q <= dec_addr;
        rem_q <= dec_len;
        last_q <= dec_last;
      end else if (step_ack) begin
        raddr_q <= raddr_q + avdma_pkg::WORD_BYTES;
        rem_q <= rem_q - avdma_pkg::WORD_BYTES;
      end
      if (first_ack) begin
        data_q <= dir_q ? i_pio_rdata : i_mem_rdata;
      end
    end
  end

  // ***************************************************
  // software registers
  // ***************************************************
  // command, table address and chunk count
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_q <= 1'b0;
      dir_q <= 1'b0;
      large_q <= 1'b0;
      prd_q <= 32'h0;
      chunk_q <= 32'h0;
    end else begin
      if (stop) begin
        en_q <= 1'b0;
      end else if (start) begin
        en_q <= 1'b1;
        dir_q <= bus.wdata[avdma_pkg::BM_DIR];
        large_q <= (bus.addr == avdma_pkg::DEV_LB_CMD);
      end
      if (wr & (bus.addr == avdma_pkg::DEV_PRD_ADDR | bus.addr == avdma_pkg::DEV_LB_PRD)) begin
        prd_q <= bus.wdata;
      end
      if (wr & (bus.addr == avdma_pkg::DEV_CHUNK)) begin
        chunk_q <= bus.wdata;
      end else if (step_ack) begin
        chunk_q <= chunk_q - avdma_pkg::WORD_BYTES;
      end
    end
  end

  // status flags: every hardware set wins over a clear in the same cycle, except devint_q, where a status read wins over the line
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      act_q <= 1'b0;
      err_q <= 1'b0;
      int_q <= 1'b0;
      vdone_q <= 1'b0;
      devint_q <= 1'b0;
    end else begin
      if (start) begin
        act_q <= 1'b1;
      end else if (stop | fail | short_tbl) begin
        act_q <= 1'b0;
      end else if (finish) begin
        act_q <= ~last_q | ~region_end;
      end
      if (fail) begin
        err_q <= 1'b1;
      end else if (w1c_err) begin
        err_q <= 1'b0;
      end
      // same flag in large mode: status is mode-blind
      if (finish | (~en_q & i_ata_intrq)) begin
        int_q <= 1'b1;
      end else if (w1c_int) begin
        int_q <= 1'b0;
      end
      if (finish | short_tbl) begin
        vdone_q <= 1'b1;
      end else if (w1c_int | w1c_err) begin
        vdone_q <= 1'b0;
      end
      // follows the line; a latched set would stick, since intrq drops a cycle after the read
      devint_q <= i_ata_intrq & ~tf_rd;
    end
  end

  // read data mux, unmapped offsets read zero
  always_comb begin
    rd_d = 32'h0;
    case (bus.addr)
      avdma_pkg::DEV_BM_CMD, avdma_pkg::DEV_LB_CMD: begin
        rd_d[avdma_pkg::BM_INT] = int_q;
        rd_d[avdma_pkg::BM_ERR] = err_q;
        rd_d[avdma_pkg::BM_ACT] = act_q;
        rd_d[avdma_pkg::BM_DIR] = dir_q;
        rd_d[avdma_pkg::BM_EN] = en_q;
      end
      avdma_pkg::DEV_PRD_ADDR, avdma_pkg::DEV_LB_PRD: rd_d = prd_q;
      avdma_pkg::DEV_TF_STAT: begin
        if (!en_q) begin
          rd_d[avdma_pkg::TF_STAT_LSB +: 8] = i_ata_status;
        end
      end
      avdma_pkg::DEV_CFG_STAT: begin
        rd_d[avdma_pkg::CFG_DEVINT] = devint_q;
        rd_d[avdma_pkg::CFG_VDONE] = vdone_q;
      end
      avdma_pkg::DEV_CHUNK: rd_d = chunk_q;
      default: rd_d = 32'h0;
    endcase
  end

  // answer every access one cycle after it is taken
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= acc;
      if (rd) begin
        rdata_q <= rd_d;
      end
    end
  end

  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;
  assign bus.intr = int_q | err_q | vdone_q;
endmodule

// *** hw/avdma_host.sv ***
`timescale 1ns/10ps
module avdma_host (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_resetn, // async reset, low
  input wire logic i_hsel, // slave select
  input wire logic [31:0] i_haddr, // byte address
  input wire logic [1:0] i_htrans, // transfer type
  input wire logic i_hwrite, // 1 = write
  input wire logic [2:0] i_hsize, // word only
  input wire logic i_hready, // bus ready
  input wire logic [31:0] i_hwdata, // write data
  output logic o_hreadyout, // always ready
  output logic [31:0] o_hrdata, // read data
  output logic o_hresp, // always OKAY
  avdma_if.host bus // register path to the channel
);
  // ***************************************************
  // declarations
  // ***************************************************
  logic aphase, wpend_q, busy_q, we_q;
  logic [7:0] haddr_q, daddr_q;
  logic [31:0] wdata_q, rdata_q, hrdata_q, rd_d;

  // ***************************************************
  // bus slave
  // ***************************************************
  assign aphase = i_hsel & i_hready & i_htrans[1];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wpend_q <= 1'b0;
      haddr_q <= 8'h0;
    end else begin
      wpend_q <= aphase & i_hwrite;
      if (aphase) begin
        haddr_q <= i_haddr[7:0];
      end
    end
  end

  // software order: one channel access per go; a go while busy is dropped
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q <= 1'b0;
      we_q <= 1'b0;
      daddr_q <= 8'h0;
      wdata_q <= 32'h0;
      rdata_q <= 32'h0;
    end else begin
      if (busy_q & bus.ack) begin
        busy_q <= 1'b0;
        rdata_q <= bus.rdata;
      end else if (wpend_q & (haddr_q == avdma_pkg::HR_CTRL) &
                   i_hwdata[avdma_pkg::HC_GO] & ~busy_q) begin
        busy_q <= 1'b1;
        we_q <= i_hwdata[avdma_pkg::HC_WR];
        daddr_q <= i_hwdata[7:0];
      end
      if (wpend_q & (haddr_q == avdma_pkg::HR_WDATA)) begin
        wdata_q <= i_hwdata;
      end
    end
  end

  // read data is sampled in the address phase, so it lags a same-cycle update
  always_comb begin
    rd_d = 32'h0;
    case (i_haddr[7:0])
      avdma_pkg::HR_CTRL: rd_d = {23'h0, we_q, daddr_q};
      avdma_pkg::HR_WDATA: rd_d = wdata_q;
      avdma_pkg::HR_RDATA: rd_d = rdata_q;
      avdma_pkg::HR_STATUS: rd_d = {30'h0, bus.intr, busy_q};
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hrdata_q <= 32'h0;
    end else if (aphase & ~i_hwrite) begin
      hrdata_q <= rd_d;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_q;

  // sequencing of chunk size, mode switches and stops stays in software
  assign bus.req = busy_q;
  assign bus.we = we_q;
  assign bus.addr = daddr_q;
  assign bus.wdata = wdata_q;
endmodule

// *** testbench/avdma_props.sv ***
`timescale 1ns/10ps
// ****************************
// register path checker
// ****************************
module avdma_props (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_resetn, // async reset, low
  input wire logic req, // access pending
  input wire logic we, // 1 = write
  input wire logic [7:0] addr, // device offset
  input wire logic [31:0] wdata, // write data
  input wire logic [31:0] rdata, // read data
  input wire logic ack, // completion pulse
  input wire logic intr // channel interrupt
);
  logic en_q;
  logic cmd_w;
  logic rd;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // command writes at either register set
  assign cmd_w = ack && we && (addr == avdma_pkg::DEV_BM_CMD || addr == avdma_pkg::DEV_LB_CMD);
  assign rd = ack && !we;
  // enable shadow; a restart while running leaves it alone
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_q <= 1'b0;
    end else if (cmd_w && (!en_q || !wdata[0])) begin
      en_q <= wdata[0];
    end
  end
  property p_ack_next;
    req && !ack |=> ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after take");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_req_drop;
    ack |=> !req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after ack");
  property p_tf_block;
    rd && addr == avdma_pkg::DEV_TF_STAT && en_q |-> rdata == 32'h0000_0000;
  endproperty
  a_tf_block: assert property (p_tf_block) else $error("task file read while enabled");
  property p_stop;
    rd && addr == avdma_pkg::DEV_BM_CMD && !en_q |-> !rdata[0] && !rdata[16];
  endproperty
  a_stop: assert property (p_stop) else $error("active bit after stop");
  property p_bm_intr;
    rd && addr == avdma_pkg::DEV_BM_CMD && (rdata[18] || rdata[17]) |-> intr;
  endproperty
  a_bm_intr: assert property (p_bm_intr) else $error("status set without interrupt");
  property p_cfg_intr;
    rd && addr == avdma_pkg::DEV_CFG_STAT && rdata[10] |-> intr;
  endproperty
  a_cfg_intr: assert property (p_cfg_intr) else $error("chunk done without interrupt");
  property p_rd_hold;
    $changed(rdata) |-> rd;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
endmodule

// *** testbench/avdma_tb.sv ***
`timescale 1ns/10ps
module avdma_tb;
  // ****************************
  // bench state
  // ****************************
  typedef struct packed {
    logic lg; logic dir; logic err; logic [63:0] d0;
    logic [7:0] cnt; logic [2:0] st; logic done; logic [7:0] words;
  } avdma_row_t;
  localparam logic [7:0] BM = avdma_pkg::DEV_BM_CMD;
  localparam logic [7:0] CFG = avdma_pkg::DEV_CFG_STAT;
  localparam logic [7:0] TF = avdma_pkg::DEV_TF_STAT;
  localparam logic [31:0] ST = {24'h0, avdma_pkg::HR_STATUS};
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, pio_rd = 32'h0, mem_rd = 32'h0;
  logic [31:0] hrdata, rd, pio_wd, mem_addr, mem_wd;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0, ata_irq = 1'b0, pio_ack = 1'b0, mem_ack = 1'b0, err_on = 1'b0;
  logic hold = 1'b0, hready, hresp, stat_rd, pio_req, pio_we, mem_req, mem_we;
  logic [7:0] ata_st = 8'h58;
  logic [7:0] off;
  logic [31:0] mem [0:63];
  int err_count = 0, n_tests = 0, cyc = 0, pio_n = 0, pio_wn = 0, n_stat = 0;
  avdma_row_t rows [8];
  avdma_if bus ();
  avdma_host u_avdma_host (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(1'b1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready), .i_hwdata(hwdata),
    .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp), .bus(bus.host));
  avdma_dev u_avdma_dev (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus.dev), .i_ata_status(ata_st),
    .i_ata_intrq(ata_irq), .o_ata_stat_rd(stat_rd), .o_pio_req(pio_req), .o_pio_we(pio_we),
    .o_pio_wdata(pio_wd), .i_pio_ack(pio_ack), .i_pio_rdata(pio_rd), .o_mem_req(mem_req),
    .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wd), .i_mem_ack(mem_ack),
    .i_mem_err(mem_ack & err_on), .i_mem_rdata(mem_rd));
  avdma_props u_avdma_props (.i_clk(i_clk), .i_resetn(i_resetn), .req(bus.req), .we(bus.we),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack), .intr(bus.intr));
  // 100 MHz clock
  always #5 i_clk = ~i_clk;
  // ****************************
  // far-side models and timeout
  // ****************************
  // one-cycle acks; hold stalls the ata side to catch a stop mid-chunk
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    pio_ack <= pio_req && !pio_ack && !hold;
    mem_ack <= mem_req && !mem_ack;
    mem_rd <= mem[mem_addr[7:2]];
    pio_rd <= pio_rd + 32'h1;
    if (mem_req && !mem_ack && mem_we) mem[mem_addr[7:2]] <= mem_wd;
    if (pio_ack) pio_n <= pio_n + 1;
    if (pio_ack && pio_we) pio_wn <= pio_wn + 1;
    // a status read drops the device interrupt line
    if (stat_rd) begin
      ata_irq <= 1'b0;
      n_stat <= n_stat + 1;
    end
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  // ****************************
  // tasks
  // ****************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // single word transfer, zero-wait slave still honoured by hready
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge i_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // one device register access through the controller
  task automatic dacc(input logic w, input logic [7:0] o, input logic [31:0] d);
    ahb(1'b1, {24'h0, avdma_pkg::HR_WDATA}, d);
    ahb(1'b1, {24'h0, avdma_pkg::HR_CTRL}, {1'b1, 22'h0, w, o});
    do ahb(1'b0, ST, 32'h0); while (rd[0] !== 1'b0);
    ahb(1'b0, {24'h0, avdma_pkg::HR_RDATA}, 32'h0);
  endtask
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************************
  // main sequence
  // ****************************
  initial begin
    rows[0] = '{1'b0, 1'b1, 1'b0, 64'h8000_0010_0000_0040, 8'h10, 3'h4, 1'b1, 8'h4};
    rows[1] = '{1'b0, 1'b0, 1'b0, 64'h8000_0020_0000_0040, 8'h10, 3'h5, 1'b1, 8'h4};
    rows[2] = '{1'b0, 1'b1, 1'b0, 64'h8000_0010_0000_FFF8, 8'h10, 3'h0, 1'b1, 8'h2};
    rows[3] = '{1'b1, 1'b1, 1'b0, 64'h8000_0010_0000_FFF8, 8'h10, 3'h4, 1'b1, 8'h4};
    rows[4] = '{1'b0, 1'b0, 1'b0, 64'h8001_0010_0000_0040, 8'h10, 3'h4, 1'b1, 8'h4};
    rows[5] = '{1'b1, 1'b0, 1'b0, 64'h8001_0000_0000_0040, 8'h10, 3'h5, 1'b1, 8'h4};
    rows[6] = '{1'b0, 1'b1, 1'b0, 64'h0000_0008_0000_0040, 8'h10, 3'h5, 1'b1, 8'h4};
    rows[7] = '{1'b0, 1'b1, 1'b1, 64'h8000_0010_0000_0040, 8'h10, 3'h2, 1'b0, 8'h0};
    mem[2] = 32'h0000_0080;
    mem[3] = 32'h8000_0040;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    // one chunk per row, serviced the way a driver would
    for (int i = 0; i < 8; i++) begin
      mem[0] = rows[i].d0[31:0];
      mem[1] = rows[i].d0[63:32];
      err_on <= rows[i].err;
      pio_n = 0;
      pio_wn = 0;
      off = rows[i].lg ? avdma_pkg::DEV_LB_CMD : BM;
      dacc(1'b1, avdma_pkg::DEV_PRD_ADDR, 32'h0);
      dacc(1'b1, avdma_pkg::DEV_CHUNK, {24'h0, rows[i].cnt});
      dacc(1'b1, off, {28'h0, rows[i].dir, 3'h1});
      do ahb(1'b0, ST, 32'h0); while (rd[1] !== 1'b1);
      dacc(1'b0, off, 32'h0);
      chk(32'(rd[18:16]), 32'(rows[i].st));
      dacc(1'b0, CFG, 32'h0);
      if (!rows[i].err) chk(32'(rd[10]), 32'(rows[i].done));
      chk(pio_n, 32'(rows[i].words));
      chk(pio_wn, rows[i].dir ? 32'h0 : 32'(rows[i].words));
      dacc(1'b0, TF, 32'h0);
      chk(rd, 32'h0);
      dacc(1'b1, off, 32'h0);
      dacc(1'b1, off, 32'h0006_0000);
      dacc(1'b0, BM, 32'h0);
      chk(rd & 32'h0007_0001, 32'h0);
      ahb(1'b0, ST, 32'h0);
      chk(32'(rd[1]), 32'h0);
      dacc(1'b0, CFG, 32'h0);
      chk(32'(rd[11]), 32'h0);
    end
    // second reset in mid-run, then idle values and an unmapped host offset
    err_on <= 1'b0;
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    dacc(1'b0, BM, 32'h0);
    chk(rd & 32'h0007_0009, 32'h0);
    ahb(1'b0, 32'h0000_0010, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    // idle device interrupt: latch, mirror, clear by status read
    ata_st <= 8'h09;
    ata_irq <= 1'b1;
    do ahb(1'b0, ST, 32'h0); while (rd[1] !== 1'b1);
    dacc(1'b0, CFG, 32'h0);
    chk(rd & 32'h0000_0C00, 32'h0000_0800);
    dacc(1'b0, BM, 32'h0);
    chk(rd & 32'h0007_0000, 32'h0004_0000);
    dacc(1'b0, TF, 32'h0);
    chk(32'(rd[31:24]), 32'h09);
    chk(n_stat, 32'h1);
    dacc(1'b0, CFG, 32'h0);
    chk(32'(rd[11]), 32'h0);
    dacc(1'b1, BM, 32'h0004_0000);
    dacc(1'b0, BM, 32'h0);
    chk(32'(rd[18]), 32'h0);
    // stop while the ata side is stalled mid-chunk
    hold <= 1'b1;
    mem[0] = 32'h0000_0040;
    mem[1] = 32'h8000_0010;
    dacc(1'b1, avdma_pkg::DEV_PRD_ADDR, 32'h0);
    dacc(1'b1, avdma_pkg::DEV_CHUNK, 32'h10);
    dacc(1'b1, BM, 32'h9);
    dacc(1'b1, BM, 32'h0);
    chk(32'(pio_req), 32'h0);
    dacc(1'b0, BM, 32'h0);
    chk(rd & 32'h0001_0001, 32'h0);
    hold <= 1'b0;
    complete_run();
  end
endmodule
